//--- design/awsc_map.vh
// constants of the area wait state controller: offsets, fields, reset values, tables
// assumes inclusion by bare name from the design files
`ifndef AWSC_MAP_VH
`define AWSC_MAP_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define AWSC_OFF_WAIT_CTRL 4'h0
`define AWSC_OFF_CONTROL 4'h4
`define AWSC_OFF_STATUS 4'h8
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define AWSC_RST_WAIT_CTRL 16'hFFFF
`define AWSC_RST_CONTROL 3'h0
// ---------------------------------------------------------------
// field positions in area_wait_control_two
// ---------------------------------------------------------------
`define AWSC_A6_LSB 13
`define AWSC_A5_LSB 10
`define AWSC_A4_LSB 7
`define AWSC_A3_LSB 5
`define AWSC_A2_LSB 3
`define AWSC_A0_LSB 0
// ---------------------------------------------------------------
// control register bits
// ---------------------------------------------------------------
`define AWSC_CTL_A2_SDRAM 0
`define AWSC_CTL_A3_SDRAM 1
`define AWSC_CTL_SAMPLE_SEL 2
// ---------------------------------------------------------------
// decode tables, one nibble or two bits per field value, value 0 lowest
// ---------------------------------------------------------------
`define AWSC_FIRST_WAITS 32'hA8643210
`define AWSC_BURST_PITCH 32'hA8644322
`define AWSC_CAS_LATENCY 8'hE5
// ---------------------------------------------------------------
// axi responses
// ---------------------------------------------------------------
`define AWSC_RESP_OKAY 2'h0
`define AWSC_RESP_SLVERR 2'h2
`endif

//--- design/awsc_sync.v
// two flip-flop synchroniser for a group of pin levels
// assumes each bit is an independent level from outside the aclk domain
`timescale 1ns/1ps
`default_nettype none
module awsc_sync #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage_one;
  always @(posedge aclk) begin
    if (!aresetn) begin
      stage_one <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule // awsc_sync
`default_nettype wire

//--- design/awsc_wait_decode.v
// decode of one area's wait field into first-cycle waits and burst pitch
// assumes a pure combinational use; narrow fields arrive in code[1:0]
`timescale 1ns/1ps
`include "awsc_map.vh"
`default_nettype none
module awsc_wait_decode (
  input wire [2:0] code,
  input wire narrow,
  input wire has_burst,
  input wire sdram,
  output reg [3:0] first_waits,
  output reg [3:0] burst_pitch,
  output reg honour_first,
  output reg honour_burst
);
  reg [31:0] first_table;
  reg [31:0] pitch_table;
  reg [7:0] cas_table;
  always @* begin
    first_table = `AWSC_FIRST_WAITS;
    pitch_table = `AWSC_BURST_PITCH;
    cas_table = `AWSC_CAS_LATENCY;
    if (narrow && sdram) begin
      // cas latency stands in for the first-cycle waits, pin not used
      first_waits = {2'h0, cas_table[{code[1:0], 1'b0} +: 2]};
      honour_first = 1'b0;
    end else if (narrow) begin
      first_waits = {2'h0, code[1:0]};
      honour_first = (code[1:0] != 2'h0);
    end else begin
      first_waits = first_table[{code, 2'h0} +: 4];
      honour_first = (code != 3'h0);
    end
    if (has_burst && !narrow) begin
      burst_pitch = pitch_table[{code, 2'h0} +: 4];
      honour_burst = 1'b1;
    end else begin
      burst_pitch = first_waits + 4'h1;
      honour_burst = honour_first;
    end
  end
endmodule // awsc_wait_decode
`default_nettype wire

//--- design/awsc_top.v
// area wait state controller: axi4-lite registers, per-area decode, bus cycle timing
// assumes a bus sequencer on aclk issuing cycle requests and an active-low wait pin
`timescale 1ns/1ps
`include "awsc_map.vh"
`default_nettype none
// Overview of operation
// - area 6 field 0..7 gives 0,1,2,3,4,6,8,10 waits; pin ignored only at 0
// - area 6 burst pitch 2,2,3,4,4,6,8,10 states, pin always honoured
// - area 5 field 0..7 gives 0,1,2,3,4,6,8,10 waits; pin ignored only at 0
// - area 5 burst pitch 2,2,3,4,4,6,8,10 states, pin always honoured
// - area 4 gives 0,1,2,3,4,6,8,10 waits, pin ignored at 0, no burst pitch
// - area 3 ordinary memory: field gives 0..3 waits, pin ignored at 0
// - area 3 synchronous dram: field gives cas latency 1,1,2,3
// - area 2 ordinary memory: field gives 0..3 waits, pin ignored at 0
// - area 2 synchronous dram: field gives cas latency 1,1,2,3
// - area 0 field 0..7 gives 0,1,2,3,4,6,8,10 waits; pin ignored only at 0
// - area 0 burst pitch 2,2,3,4,4,6,8,10 states, pin always honoured
// - power-on reset sets wait control to all ones; manual reset keeps it
// - with sample select set, wait pin sampled at bus clock falling edge
module awsc_top #(
  parameter BURST_WIDTH = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire manual_resetn,
  input wire wait_n,
  input wire cycle_start,
  input wire [2:0] cycle_area,
  input wire [BURST_WIDTH-1:0] cycle_extra,
  output reg cycle_busy,
  output reg data_strobe,
  output reg cycle_done,
  output reg bus_clock_output,
  output reg [1:0] area2_cas_latency,
  output reg [1:0] area3_cas_latency
);
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_FIRST = 2'h1;
  localparam [1:0] ST_BURST = 2'h2;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg [15:0] area_wait_control_two;
  reg [2:0] control;
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [1:0] state;
  reg [3:0] count;
  reg [BURST_WIDTH-1:0] remaining;
  reg [2:0] area;
  reg honour;
  reg pending;
  reg [2:0] pending_area;
  reg [BURST_WIDTH-1:0] pending_extra;
  reg [1:0] next_state;
  reg [3:0] next_count;
  reg [BURST_WIDTH-1:0] next_remaining;
  reg next_honour;
  reg next_strobe;
  reg next_done;
  reg [31:0] status_word;
  reg [31:0] read_word;
  reg [1:0] read_resp;
  wire [7:0] cas_table = `AWSC_CAS_LATENCY;
  wire [1:0] pin_sync;
  wire wait_low;
  wire manual_low;
  wire tick;
  wire sample_select;
  wire stall_seen;
  wire [23:0] area_code;
  wire [7:0] narrow_mask;
  wire [7:0] burst_mask;
  wire [7:0] sdram_mask;
  wire [31:0] waits_all;
  wire [31:0] pitch_all;
  wire [7:0] honour_first_all;
  wire [7:0] honour_burst_all;
  wire write_go;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  awsc_sync #(
    .WIDTH(2),
    .RESET_VALUE(2'h3)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({manual_resetn, wait_n}),
    .sync_out(pin_sync)
  );
  assign wait_low = ~pin_sync[0];
  assign manual_low = ~pin_sync[1];

  // ---------------------------------------------------------------
  // bus clock output, one bus state per two aclk cycles
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      bus_clock_output <= 1'b0;
    end else begin
      bus_clock_output <= ~bus_clock_output;
    end
  end
  // tick marks the edge at which the bus clock output falls
  assign tick = bus_clock_output;
  assign sample_select = control[`AWSC_CTL_SAMPLE_SEL];
  // pin is looked at only on the falling edge and only with sampling selected
  assign stall_seen = tick && sample_select && wait_low;

  // ---------------------------------------------------------------
  // per-area field selection and decode
  // ---------------------------------------------------------------
  assign area_code[2:0] = area_wait_control_two[`AWSC_A0_LSB +: 3];
  assign area_code[5:3] = 3'h0;
  assign area_code[8:6] = {1'b0, area_wait_control_two[`AWSC_A2_LSB +: 2]};
  assign area_code[11:9] = {1'b0, area_wait_control_two[`AWSC_A3_LSB +: 2]};
  assign area_code[14:12] = area_wait_control_two[`AWSC_A4_LSB +: 3];
  assign area_code[17:15] = area_wait_control_two[`AWSC_A5_LSB +: 3];
  assign area_code[20:18] = area_wait_control_two[`AWSC_A6_LSB +: 3];
  assign area_code[23:21] = 3'h0;
  assign narrow_mask = 8'h0C;
  // areas 0, 5 and 6 carry a burst pitch, area 4 does not
  assign burst_mask = 8'h61;
  assign sdram_mask = {4'h0, control[`AWSC_CTL_A3_SDRAM], control[`AWSC_CTL_A2_SDRAM], 2'h0};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_area
      awsc_wait_decode u_dec (
        .code(area_code[3*gi +: 3]),
        .narrow(narrow_mask[gi]),
        .has_burst(burst_mask[gi]),
        .sdram(sdram_mask[gi]),
        .first_waits(waits_all[4*gi +: 4]),
        .burst_pitch(pitch_all[4*gi +: 4]),
        .honour_first(honour_first_all[gi]),
        .honour_burst(honour_burst_all[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // cas latency outputs for areas 2 and 3
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      area2_cas_latency <= 2'h3;
      area3_cas_latency <= 2'h3;
    end else begin
      area2_cas_latency <= cas_table[{area_wait_control_two[`AWSC_A2_LSB +: 2], 1'b0} +: 2];
      area3_cas_latency <= cas_table[{area_wait_control_two[`AWSC_A3_LSB +: 2], 1'b0} +: 2];
    end
  end

  // ---------------------------------------------------------------
  // cycle request capture
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn || manual_low) begin
      pending <= 1'b0;
      pending_area <= 3'h0;
      pending_extra <= {BURST_WIDTH{1'b0}};
      cycle_busy <= 1'b0;
    end else begin
      if (cycle_start && !cycle_busy) begin
        pending <= 1'b1;
        pending_area <= cycle_area;
        pending_extra <= cycle_extra;
        cycle_busy <= 1'b1;
      end else begin
        if (tick && state == ST_IDLE) begin
          pending <= 1'b0;
        end
        if (next_done) begin
          cycle_busy <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // wait state sequencer
  // ---------------------------------------------------------------
  always @* begin
    next_state = state;
    next_count = count;
    next_remaining = remaining;
    next_honour = honour;
    next_strobe = 1'b0;
    next_done = 1'b0;
    if (tick) begin
      case (state)
        ST_IDLE: begin
          if (pending) begin
            next_state = ST_FIRST;
            next_count = waits_all[4*pending_area +: 4];
            next_honour = honour_first_all[pending_area];
            next_remaining = pending_extra;
          end
        end
        ST_FIRST, ST_BURST: begin
          if (count != 4'h0) begin
            next_count = count - 4'h1;
          end else if (honour && stall_seen) begin
            next_count = 4'h0;
          end else begin
            next_strobe = 1'b1;
            if (remaining == {BURST_WIDTH{1'b0}}) begin
              next_state = ST_IDLE;
              next_done = 1'b1;
            end else begin
              next_state = ST_BURST;
              next_remaining = remaining - {{(BURST_WIDTH-1){1'b0}}, 1'b1};
              next_count = pitch_all[4*area +: 4] - 4'h1;
              next_honour = honour_burst_all[area];
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn || manual_low) begin
      state <= ST_IDLE;
      count <= 4'h0;
      remaining <= {BURST_WIDTH{1'b0}};
      honour <= 1'b0;
      area <= 3'h0;
      data_strobe <= 1'b0;
      cycle_done <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      remaining <= next_remaining;
      honour <= next_honour;
      data_strobe <= next_strobe;
      cycle_done <= next_done;
      if (tick && state == ST_IDLE && pending) begin
        area <= pending_area;
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign write_go = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AWSC_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (write_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `AWSC_OFF_WAIT_CTRL || aw_addr == `AWSC_OFF_CONTROL ||
            aw_addr == `AWSC_OFF_STATUS) begin
          s_axi_bresp <= `AWSC_RESP_OKAY;
        end else begin
          s_axi_bresp <= `AWSC_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers, kept through manual reset
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      area_wait_control_two <= `AWSC_RST_WAIT_CTRL;
      control <= `AWSC_RST_CONTROL;
    end else if (write_go) begin
      if (aw_addr == `AWSC_OFF_WAIT_CTRL) begin
        if (w_strb[0]) begin
          area_wait_control_two[7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          area_wait_control_two[15:8] <= w_data[15:8];
        end
      end
      if (aw_addr == `AWSC_OFF_CONTROL && w_strb[0]) begin
        control <= w_data[2:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  always @* begin
    status_word = 32'h00000000;
    status_word[0] = cycle_busy;
    status_word[2:1] = state;
    status_word[6:4] = area;
    status_word[7] = wait_low;
    status_word[11:8] = count;
    status_word[15:12] = remaining[3:0];
    read_resp = `AWSC_RESP_OKAY;
    case (s_axi_araddr)
      `AWSC_OFF_WAIT_CTRL: begin
        read_word = {16'h0000, area_wait_control_two};
      end
      `AWSC_OFF_CONTROL: begin
        read_word = {29'h00000000, control};
      end
      `AWSC_OFF_STATUS: begin
        read_word = status_word;
      end
      default: begin
        read_word = 32'h00000000;
        read_resp = `AWSC_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `AWSC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_word;
        s_axi_rresp <= read_resp;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // awsc_top
`default_nettype wire

//--- verif/awsc_wait_partner.sv
// far-side memory model driving the active-low wait pin
// assumes the bench sets hold_cycles before a bus cycle starts
`timescale 1ns/1ps
`default_nettype none
module awsc_wait_partner (
  input wire logic aclk,
  input wire logic cycle_busy,
  input wire logic [7:0] hold_cycles,
  output logic wait_n
);
  logic prev_busy = 1'b0;
  logic hold_low = 1'b0;
  logic [7:0] left = 8'h00;
  // released pin rests at the pull-up level
  assign wait_n = ~hold_low;
  // ----------------------------------------
  // hold the cycle, then release to the pull-up level
  // ----------------------------------------
  always @(posedge aclk) begin
    prev_busy <= cycle_busy;
    if (cycle_busy && !prev_busy && hold_cycles != 8'h00) begin
      left <= hold_cycles;
      hold_low <= 1'b1;
    end else if (left > 8'h01) begin
      left <= left - 8'h01;
    end else begin
      left <= 8'h00;
      hold_low <= 1'b0;
    end
  end
endmodule // awsc_wait_partner
`default_nettype wire

//--- verif/awsc_top_properties.sv
// port checker of the area wait state controller
// assumes a bind into awsc_top, clock aclk, synchronous reset aresetn
`timescale 1ns/1ps
`default_nettype none
module awsc_top_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic cycle_start,
  input wire logic cycle_busy,
  input wire logic data_strobe,
  input wire logic cycle_done,
  input wire logic bus_clock_output
);
  // ----------------------------------------
  // cycle timing and bus answers
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence take_s;
    cycle_start && !cycle_busy;
  endsequence
  sequence quiet_s;
    !data_strobe [*3];
  endsequence
  chk_take_busy: assert property (take_s |=> cycle_busy)
    else $error("request not taken");
  chk_first_gap: assert property (take_s |=> quiet_s)
    else $error("strobe too soon after request");
  chk_strobe_pulse: assert property (data_strobe |=> !data_strobe)
    else $error("strobe longer than one cycle");
  chk_done_last: assert property (cycle_done |-> data_strobe && !cycle_busy)
    else $error("done without final strobe");
  chk_strobe_busy: assert property (data_strobe |-> $past(cycle_busy))
    else $error("strobe outside a cycle");
  chk_bus_clock: assert property (bus_clock_output |=> !bus_clock_output)
    else $error("bus clock stuck high");
  chk_write_hold: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during response");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
endmodule // awsc_top_properties
bind awsc_top awsc_top_properties awsc_top_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .cycle_start(cycle_start), .cycle_busy(cycle_busy),
  .data_strobe(data_strobe), .cycle_done(cycle_done), .bus_clock_output(bus_clock_output)
);
`default_nettype wire

//--- verif/awsc_top_bench.sv
// self-checking bench of the area wait state controller
// assumes awsc_top, awsc_wait_partner and the bound checker
`timescale 1ns/1ps
`include "awsc_map.vh"
`default_nettype none
module awsc_top_bench;
  logic aclk = 1'b0, aresetn = 1'b0, manual_resetn = 1'b1, wait_n;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF, cycle_extra = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, cycle_area = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cycle_start = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, area2_cas_latency, area3_cas_latency;
  logic cycle_busy, data_strobe, cycle_done, bus_clock_output;
  logic [7:0] hold_cycles = '0;
  int mismatches = 0, checked = 0;
  int wt[8] = '{0, 1, 2, 3, 4, 6, 8, 10};
  int pt[8] = '{2, 2, 3, 4, 4, 6, 8, 10};
  int cas[4] = '{1, 1, 2, 3};
  awsc_top awsc_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .manual_resetn(manual_resetn),
    .wait_n(wait_n), .cycle_start(cycle_start), .cycle_area(cycle_area), .cycle_extra(cycle_extra),
    .cycle_busy(cycle_busy), .data_strobe(data_strobe), .cycle_done(cycle_done),
    .bus_clock_output(bus_clock_output), .area2_cas_latency(area2_cas_latency),
    .area3_cas_latency(area3_cas_latency)
  );
  awsc_wait_partner awsc_wait_partner_inst (
    .aclk(aclk), .cycle_busy(cycle_busy), .hold_cycles(hold_cycles), .wait_n(wait_n)
  );
  initial forever #25 aclk = ~aclk;
  // ----------------------------------------
  // report, compare and bus tasks
  // ----------------------------------------
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check_val(string name, logic [31:0] exp, logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h got %h", name, exp, seen);
    end
  endtask
  task automatic check_rng(string name, int lo, int hi, int seen);
    checked++;
    if (seen < lo || seen > hi) begin
      mismatches++;
      $display("BAD %s exp %0d..%0d got %0d", name, lo, hi, seen);
    end
  endtask
  task automatic guard(int n);
    if (n >= 400) begin
      mismatches++;
      $display("BAD wait exp answer got timeout");
      finish_test;
    end
  endtask
  task automatic axi_wr(logic [3:0] a, logic [31:0] d, logic [1:0] exp);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 400);
    guard(n);
    check_val("bresp", exp, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(logic [3:0] a, logic [31:0] exp, logic [1:0] exp_resp);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 400);
    guard(n);
    check_val("rresp", exp_resp, s_axi_rresp);
    if (exp_resp == 2'h0) check_val("rdata", exp, s_axi_rdata);
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [15:0] fld(logic [15:0] b, int lsb, int m, int v);
    return (b & ~(16'(m) << lsb)) | (16'(v) << lsb);
  endfunction
  task automatic run_cycle(int area, int extra, output int t1, output int t2);
    int t = 0;
    t1 = 0;
    t2 = 0;
    @(posedge aclk);
    cycle_area <= 3'(area);
    cycle_extra <= 4'(extra);
    cycle_start <= 1'b1;
    @(posedge aclk);
    cycle_start <= 1'b0;
    do begin
      @(posedge aclk);
      t++;
      if (data_strobe && t1 == 0) t1 = t;
      else if (data_strobe) t2 = t;
    end while (!cycle_done && t < 400);
    guard(t);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_regs;
    axi_rd(4'h0, 32'h0000FFFF, 2'h0);
    axi_rd(4'h4, 32'h00000000, 2'h0);
    axi_rd(4'h8, 32'h00000000, 2'h0);
    check_val("cas2", 32'h3, area2_cas_latency);
    check_val("cas3", 32'h3, area3_cas_latency);
    axi_wr(4'hC, 32'h0, 2'h2);
    axi_rd(4'hC, 32'h0, 2'h2);
    axi_wr(4'h0, 32'hABCD1234, 2'h0);
    @(posedge aclk);
    manual_resetn <= 1'b0;
    repeat (4) @(posedge aclk);
    manual_resetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(4'h0, 32'h00001234, 2'h0);
    $display("register test done");
  endtask
  task automatic test_long;
    int lsb[4] = '{`AWSC_A0_LSB, `AWSC_A5_LSB, `AWSC_A6_LSB, `AWSC_A4_LSB};
    int ar[4] = '{0, 5, 6, 4};
    int t1, t2;
    for (int a = 0; a < 4; a++)
      for (int v = 0; v < 8; v++) begin
        axi_wr(4'h0, {16'h0, fld(16'hFFFF, lsb[a], 7, v)}, 2'h0);
        run_cycle(ar[a], a == 3 ? 0 : 1, t1, t2);
        check_rng("first", 2 * wt[v] + 4, 2 * wt[v] + 5, t1);
        if (a != 3) check_val("pitch", 2 * pt[v], t2 - t1);
      end
    $display("three-bit area test done");
  endtask
  task automatic test_short;
    int t1, t2, w;
    for (int sd = 0; sd < 2; sd++)
      for (int v = 0; v < 4; v++) begin
        axi_wr(4'h4, sd ? 32'h3 : 32'h0, 2'h0);
        axi_wr(4'h0, {16'h0, fld(fld(16'hFFFF, `AWSC_A2_LSB, 3, v), `AWSC_A3_LSB, 3, v)}, 2'h0);
        w = sd ? cas[v] : v;
        run_cycle(2, 0, t1, t2);
        check_rng("area2 first", 2 * w + 4, 2 * w + 5, t1);
        run_cycle(3, 0, t1, t2);
        check_rng("area3 first", 2 * w + 4, 2 * w + 5, t1);
        check_val("cas2", cas[v], area2_cas_latency);
        check_val("cas3", cas[v], area3_cas_latency);
      end
    $display("two-bit area test done");
  endtask
  task automatic test_wait;
    int lo[2] = '{4, 22};
    int hi[2] = '{5, 34};
    int t1, t2;
    axi_wr(4'h4, 32'h4, 2'h0);
    for (int k = 0; k < 2; k++) begin
      axi_wr(4'h0, {16'h0, fld(16'hFFFF, `AWSC_A0_LSB, 7, k)}, 2'h0);
      @(posedge aclk);
      hold_cycles <= 8'h14;
      run_cycle(0, 0, t1, t2);
      hold_cycles <= 8'h00;
      check_rng("held first", lo[k], hi[k], t1);
    end
    $display("wait pin test done");
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs;
    test_long;
    test_short;
    test_wait;
    finish_test;
  end
endmodule // awsc_top_bench
`default_nettype wire
